// File: core/pewhst_defs.vh
`ifndef PEWHST_DEFS_VH
`define PEWHST_DEFS_VH
// command codes on the user port
`define PEWH_CMD_READ   2'h0
`define PEWH_CMD_LOAD   2'h1
`define PEWH_CMD_POLL   2'h2
// timing figures as printed
`define PEWH_REF_MHZ          100
`define PEWH_ADDR_SETUP_NS    20
`define PEWH_WRITE_PULSE_NS   150
`define PEWH_ACCESS_NS        250
`define PEWH_RELEASE_NS       80
`define PEWH_LOAD_GAP_NS      200
`define PEWH_POLL_START_US    600
// cycle counts: least times round up
`define PEWH_CYC_SETUP   ((`PEWH_ADDR_SETUP_NS * `PEWH_REF_MHZ + 999) / 1000)
`define PEWH_CYC_PULSE   ((`PEWH_WRITE_PULSE_NS * `PEWH_REF_MHZ + 999) / 1000)
`define PEWH_CYC_ACCESS  ((`PEWH_ACCESS_NS * `PEWH_REF_MHZ + 999) / 1000)
`define PEWH_CYC_RELEASE ((`PEWH_RELEASE_NS * `PEWH_REF_MHZ + 999) / 1000)
`define PEWH_CYC_GAP     ((`PEWH_LOAD_GAP_NS * `PEWH_REF_MHZ + 999) / 1000)
`define PEWH_CYC_POLLWT  (`PEWH_POLL_START_US * `PEWH_REF_MHZ)
`define PEWH_PAGE_BYTES  64
`define PEWH_CNT_W       16
`endif

// File: core/pewhst_host.v
// Function
// R1: full-array erase is optional and unspecified; this host never issues it.
// R2: reads present address, chip select low, write strobe high, then output enable low.
// R3: device read paths are transparent; host samples data after access time.
// R4: write starts only with address valid, select low, strobe low, output enable high.
// R5: device latches address and output enable on later falling control edge.
// R6: device latches data on the earlier rising control edge.
// R7: host meets address, enable and data setup and hold around control edges.
// R8: device erases each byte itself; host sends no erase.
// R9: one to 64 bytes per page, any order.
// R10: row address captured on first byte; host keeps row fixed during a page.
// R11: column address captured on every byte initiation.
// R12: host holds write strobe low for at least the minimum pulse width.
// R13: rising strobe starts page timer, falling strobe clears it.
// R14: no new byte within window ends page load and starts programming.
// R15: programming lasts at most 10 ms and ignores writes.
// R16: host may stretch a page by holding write strobe low.
// R17: busy reads return inverted last byte.
// R18: after programming, last address reads true byte.
// R19: host polls last address until true byte, after start delay.
// R20: device needs a fresh falling write strobe after power up.
// R21: any non-write control state inhibits writes.
// R22: select low, enable low, strobe high drives data; select high floats it.
// R23: byte loads spaced at least 0.2 us; timer waits at least 300 us.
// R24: device ignores control pulses under 20 ns.
// R25: host waits up to 600 us before trusting a polling read.
// R26: after programming the device returns idle and next write opens a page.
`timescale 1ns/10ps
`include "pewhst_defs.vh"
module pewhst_host #(
  parameter AW         = 15,
  parameter DW         = 8,
  parameter COL_W      = 6,
  parameter POLL_WAIT  = `PEWH_CYC_POLLWT
) (
  input  wire          REF_CLK,
  input  wire          RST,
  input  wire          REQ_VALID,
  output wire          REQ_READY,
  input  wire [1:0]    REQ_CMD,
  input  wire [AW-1:0] REQ_ADDR,
  input  wire [DW-1:0] REQ_DATA,
  input  wire          REQ_HOLD,
  output reg           RSP_VALID,
  output reg  [DW-1:0] RSP_DATA,
  output reg           RSP_DONE,
  output reg  [AW-1:0] ADDR,
  output reg           CE_N,
  output reg           OE_N,
  output reg           WE_N,
  output reg  [DW-1:0] DATA_OUT,
  output reg           DATA_OE,
  input  wire [DW-1:0] DATA_IN
);
  localparam [6:0] S_IDLE  = 7'h01;
  localparam [6:0] S_SETUP = 7'h02;
  localparam [6:0] S_PULSE = 7'h04;
  localparam [6:0] S_RDACC = 7'h08;
  localparam [6:0] S_REL   = 7'h10;
  localparam [6:0] S_WAIT  = 7'h20;
  localparam [6:0] S_STR   = 7'h40;
  // cycle figures are 32-bit; cut to counter width on purpose
  localparam integer           I_SETUP = `PEWH_CYC_SETUP;
  localparam integer           I_PULSE = `PEWH_CYC_PULSE;
  localparam integer           I_ACC   = `PEWH_CYC_ACCESS;
  localparam integer           I_REL   = `PEWH_CYC_RELEASE;
  localparam integer           I_GAP   = `PEWH_CYC_GAP;
  localparam [`PEWH_CNT_W-1:0] C_SETUP = I_SETUP[`PEWH_CNT_W-1:0];
  localparam [`PEWH_CNT_W-1:0] C_PULSE = I_PULSE[`PEWH_CNT_W-1:0];
  localparam [`PEWH_CNT_W-1:0] C_ACC   = I_ACC[`PEWH_CNT_W-1:0];
  localparam [`PEWH_CNT_W-1:0] C_REL   = I_REL[`PEWH_CNT_W-1:0];
  localparam [`PEWH_CNT_W-1:0] C_GAP   = I_GAP[`PEWH_CNT_W-1:0];
  localparam [31:0]            C_POLL  = POLL_WAIT;

  reg  [6:0]             state;
  reg  [`PEWH_CNT_W-1:0] cnt;
  reg  [`PEWH_CNT_W-1:0] gap_cnt;
  reg  [31:0]            poll_cnt;
  reg  [DW-1:0]          din_s1;
  reg  [DW-1:0]          din_s2;
  reg  [DW-1:0]          last_data;
  reg  [1:0]             cmd;
  reg                    hold;
  reg                    page_open;
  reg  [AW-COL_W-1:0]    page_row;
  wire                   poll_ok;

  assign REQ_READY = (state == S_IDLE);
  assign poll_ok   = (poll_cnt == 32'h0);

  always @(posedge REF_CLK)
  begin
    // data pins are asynchronous to our clock
    din_s1 <= DATA_IN;
    din_s2 <= din_s1;
  end

  always @(posedge REF_CLK)
  begin
    if (RST)
    begin
      state     <= S_IDLE;
      cnt       <= {`PEWH_CNT_W{1'b0}};
      gap_cnt   <= {`PEWH_CNT_W{1'b0}};
      poll_cnt  <= 32'h0;
      cmd       <= `PEWH_CMD_READ;
      hold      <= 1'b0;
      page_open <= 1'b0;
      page_row  <= {(AW-COL_W){1'b0}};
      last_data <= {DW{1'b0}};
      ADDR      <= {AW{1'b0}};
      CE_N      <= 1'b1;
      OE_N      <= 1'b1;
      WE_N      <= 1'b1;
      DATA_OUT  <= {DW{1'b0}};
      DATA_OE   <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_DATA  <= {DW{1'b0}};
      RSP_DONE  <= 1'b0;
    end
    else
    begin
      RSP_VALID <= 1'b0;
      // done flag stands only beside its answer
      RSP_DONE  <= 1'b0;
      if (gap_cnt != {`PEWH_CNT_W{1'b0}})
        gap_cnt <= gap_cnt - {{(`PEWH_CNT_W-1){1'b0}}, 1'b1};
      if (!poll_ok)
        poll_cnt <= poll_cnt - 32'h1;
      if (cnt != {`PEWH_CNT_W{1'b0}})
        cnt <= cnt - {{(`PEWH_CNT_W-1){1'b0}}, 1'b1};
      case (state)
        S_IDLE:
        begin
          if (REQ_VALID)
          begin
            cmd  <= REQ_CMD;
            hold <= REQ_HOLD;
            // R10: row pinned while page open
            ADDR <= (REQ_CMD == `PEWH_CMD_LOAD && page_open) ?
                    {page_row, REQ_ADDR[COL_W-1:0]} : REQ_ADDR;
            CE_N <= 1'b0;
            // R1: oe only at logic levels, no erase
            OE_N <= 1'b1;
            WE_N <= 1'b1;
            cnt  <= C_SETUP;
            if (REQ_CMD == `PEWH_CMD_LOAD)
            begin
              // R8: plain byte load, no erase command
              DATA_OUT  <= REQ_DATA;
              DATA_OE   <= 1'b1;
              last_data <= REQ_DATA;
              if (!page_open)
                page_row <= REQ_ADDR[AW-1:COL_W];
              page_open <= 1'b1;
            end
            state <= S_SETUP;
          end
        end
        S_SETUP:
        begin
          if (cnt == {`PEWH_CNT_W{1'b0}})
          begin
            if (cmd == `PEWH_CMD_LOAD)
            begin
              // R23: loads kept apart by the 0.2 us load gap
              if (gap_cnt == {`PEWH_CNT_W{1'b0}})
              begin
                // R4: write state, oe high
                WE_N  <= 1'b0;
                cnt   <= C_PULSE;
                state <= S_PULSE;
              end
            end
            else
            begin
              // R2: read with strobe high
              OE_N  <= 1'b0;
              cnt   <= C_ACC;
              state <= S_RDACC;
            end
          end
        end
        S_PULSE:
        begin
          // R12: minimum pulse width
          if (cnt == {`PEWH_CNT_W{1'b0}})
            state <= S_STR;
        end
        S_STR:
        begin
          // R16: stretch page load
          hold <= REQ_HOLD;
          if (!hold)
          begin
            // R6: data latched on this rise
            WE_N  <= 1'b1;
            cnt   <= C_REL;
            gap_cnt <= C_GAP;
            // R25: restart wait after each load
            poll_cnt <= C_POLL;
            state <= S_REL;
          end
        end
        S_RDACC:
        begin
          // R3: sample after access time plus sync
          if (cnt == {`PEWH_CNT_W{1'b0}})
            state <= S_WAIT;
        end
        S_WAIT:
        begin
          RSP_VALID <= 1'b1;
          RSP_DATA  <= din_s2;
          // R19: true byte only after start delay
          RSP_DONE  <= (cmd == `PEWH_CMD_POLL) && poll_ok && (din_s2 == last_data);
          if (cmd == `PEWH_CMD_POLL && poll_ok && din_s2 == last_data)
            page_open <= 1'b0;
          OE_N  <= 1'b1;
          cnt   <= C_REL;
          state <= S_REL;
        end
        S_REL:
        begin
          // R7: address and data held past the rise
          // R22: release bus before next cycle
          CE_N    <= 1'b1;
          DATA_OE <= 1'b0;
          if (cnt == {`PEWH_CNT_W{1'b0}})
            state <= S_IDLE;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule // pewhst_host

// File: verif/pewhst_host_assertions.sv
`timescale 1ns/10ps
module pewhst_host_assertions (
  input wire        REF_CLK,
  input wire        RST,
  input wire [14:0] ADDR,
  input wire        CE_N,
  input wire        OE_N,
  input wire        WE_N,
  input wire [7:0]  DATA_OUT,
  input wire        DATA_OE,
  input wire        REQ_HOLD,
  input wire        RSP_VALID,
  input wire        RSP_DONE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  AST_READ_CTRL: assert property (!OE_N |-> WE_N && !CE_N && !DATA_OE) else $error("read ctl");
  AST_WRITE_STATE: assert property (!WE_N |-> OE_N && !CE_N && DATA_OE) else $error("write ctl");
  AST_ADDR_SETUP: assert property ($fell(WE_N) |-> ADDR == $past(ADDR, 2)) else $error("setup");
  AST_ADDR_HOLD: assert property (!WE_N |-> $stable(ADDR) && $stable(OE_N)) else $error("hold");
  AST_DATA_SETUP: assert property ($rose(WE_N) |-> DATA_OE && DATA_OUT == $past(DATA_OUT, 5)) else $error("data");
  AST_PULSE_MIN: assert property ($fell(WE_N) |-> !WE_N [*8] ##1 !WE_N [*7]) else $error("pulse");
  AST_STRETCH: assert property (!WE_N && REQ_HOLD && $past(REQ_HOLD) && !$past(WE_N, 17)
    |=> !WE_N) else $error("stretch");
  AST_LOAD_GAP: assert property ($rose(WE_N) |-> WE_N [*8] ##1 WE_N [*8] ##1 WE_N [*4]) else $error("gap");
  AST_DONE_PAIR: assert property (RSP_DONE |-> RSP_VALID) else $error("done");
endmodule // pewhst_host_assertions

// File: verif/pewhst_rom_model.sv
`timescale 1ns/10ps
module pewhst_rom_model #(
  parameter WIN  = 400,
  parameter PROG = 3000
) (
  input  wire [14:0] ADDR,
  input  wire        CE_N,
  input  wire        OE_N,
  input  wire        WE_N,
  input  wire [7:0]  DATA_OUT,
  output reg  [7:0]  DATA_IN
);
  reg [7:0]  mem [0:32767];
  reg [7:0]  last;
  reg [14:0] a;
  reg [8:0]  row;
  reg        busy = 0, open = 0, armed = 0;
  realtime   t = 0;
  wire       ctl = CE_N | WE_N;
  always @(negedge ctl)
  begin
    armed = OE_N && !busy;
    if (armed && !open)
      row = ADDR[14:6];
    open = open | armed;
    a = {row, ADDR[5:0]};
    t = $realtime;
  end
  always @(posedge ctl)
    if (armed && $realtime - t >= 20)
    begin
      mem[a] = DATA_OUT;
      last = DATA_OUT;
      armed = 0;
      t = $realtime;
    end
  initial
    forever
    begin
      #100;
      if (open && ctl && $realtime - t >= WIN)
      begin
        busy = 1;
        #PROG busy = 0;
        open = 0;
      end
    end
  // released bus shows a non-stale pattern
  always @*
    DATA_IN = (CE_N | OE_N | !WE_N) ? ADDR[7:0] ^ 8'ha5 : busy ? ~last : mem[ADDR];
endmodule // pewhst_rom_model

// File: verif/tb_pewhst_host.sv
`timescale 1ns/10ps
`include "pewhst_defs.vh"
module tb_pewhst_host;
  reg         REF_CLK = 0, RST = 1, REQ_VALID = 0, REQ_HOLD = 0;
  reg  [1:0]  REQ_CMD = 0;
  reg  [14:0] REQ_ADDR = 0;
  reg  [7:0]  REQ_DATA = 0, d;
  reg         dn;
  wire        REQ_READY, RSP_VALID, RSP_DONE, CE_N, OE_N, WE_N, DATA_OE;
  wire [14:0] ADDR;
  wire [7:0]  RSP_DATA, DATA_OUT, DATA_IN;
  integer     n_fail = 0, checks = 0;
  always #5 REF_CLK = ~REF_CLK;
  pewhst_host #(.POLL_WAIT(80)) u_dut (.REF_CLK(REF_CLK), .RST(RST), .REQ_VALID(REQ_VALID),
    .REQ_READY(REQ_READY), .REQ_CMD(REQ_CMD), .REQ_ADDR(REQ_ADDR), .REQ_DATA(REQ_DATA), .REQ_HOLD(REQ_HOLD),
    .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA), .RSP_DONE(RSP_DONE), .ADDR(ADDR), .CE_N(CE_N), .OE_N(OE_N),
    .WE_N(WE_N), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .DATA_IN(DATA_IN));
  pewhst_rom_model u_mem (.ADDR(ADDR), .CE_N(CE_N), .OE_N(OE_N), .WE_N(WE_N),
    .DATA_OUT(DATA_OUT), .DATA_IN(DATA_IN));
  task close_out;
  begin
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  task cmp(input [7:0] g, input [7:0] e);
  begin
    checks = checks + 1;
    if (g !== e)
    begin
      n_fail = n_fail + 1;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  end
  endtask
  // a request is held until the edge that takes it
  task go(input [1:0] c, input [14:0] a, input [7:0] v, input h);
    integer k;
  begin
    @(posedge REF_CLK);
    REQ_VALID <= 1'h1;
    REQ_CMD <= c;
    REQ_ADDR <= a;
    REQ_DATA <= v;
    REQ_HOLD <= h;
    for (k = 0; k < 999 && REQ_READY !== 1'h1; k = k + 1)
      @(negedge REF_CLK);
    if (REQ_READY !== 1'h1)
      cmp(8'h00, 8'hff);
    if (REQ_READY !== 1'h1)
      close_out;
    @(posedge REF_CLK);
    REQ_VALID <= 1'h0;
  end
  endtask
  task rd(input [1:0] c, input [14:0] a);
    integer k;
  begin
    go(c, a, 8'h00, 1'h0);
    for (k = 0; k < 999 && RSP_VALID !== 1'h1; k = k + 1)
      @(negedge REF_CLK);
    if (RSP_VALID !== 1'h1)
      cmp(8'h00, 8'hff);
    if (RSP_VALID !== 1'h1)
      close_out;
    d = RSP_DATA;
    dn = RSP_DONE;
  end
  endtask
  task poll(input [14:0] a, input [7:0] v);
    integer k;
  begin
    for (k = 0; k < 50; k = k + 1)
      if (dn !== 1'h1)
        rd(`PEWH_CMD_POLL, a);
    cmp({7'h00, dn}, 8'h01);
    cmp(d, v);
  end
  endtask
  task s_page;
  begin
    dn = 0;
    go(`PEWH_CMD_LOAD, 15'h0105, 8'h3c, 1'h0);
    go(`PEWH_CMD_LOAD, 15'h7f02, 8'hc3, 1'h1);
    repeat (30) @(negedge REF_CLK);
    cmp({7'h00, WE_N}, 8'h00);
    @(posedge REF_CLK);
    REQ_HOLD <= 1'h0;
    go(`PEWH_CMD_LOAD, 15'h0100, 8'h81, 1'h0);
    // let the load timer run out so the poll meets programming
    repeat (70) @(negedge REF_CLK);
    rd(`PEWH_CMD_POLL, 15'h0100);
    cmp(d, 8'h7e);
    poll(15'h0100, 8'h81);
    rd(`PEWH_CMD_READ, 15'h0102);
    cmp(d, 8'hc3);
  end
  endtask
  task s_byte;
  begin
    dn = 0;
    go(`PEWH_CMD_LOAD, 15'h2a3f, 8'h55, 1'h0);
    rd(`PEWH_CMD_POLL, 15'h2a3f);
    cmp({7'h00, dn}, 8'h00);
    rd(`PEWH_CMD_READ, 15'h0105);
    cmp(d, 8'haa);
    poll(15'h2a3f, 8'h55);
    rd(`PEWH_CMD_READ, 15'h2a3f);
    cmp(d, 8'h55);
  end
  endtask
  initial
  begin
    repeat (5) @(posedge REF_CLK);
    RST <= 1'h0;
    s_page;
    s_byte;
    close_out;
  end
endmodule // tb_pewhst_host
bind pewhst_host pewhst_host_assertions u_chk (.REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR), .CE_N(CE_N),
  .OE_N(OE_N), .WE_N(WE_N), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .REQ_HOLD(REQ_HOLD),
  .RSP_VALID(RSP_VALID), .RSP_DONE(RSP_DONE));
